// File: pkg/pci_regs.svh
// Constants for the port change interrupt logic.
`ifndef PCI_REGS_SVH
`define PCI_REGS_SVH
`define PCI_PORT_WIDTH 8
`define PCI_CFG_CLEAR_SEL_BIT 0
`define PCI_CFG_POLARITY_BIT 1
`define PCI_CFG_OPEN_DRAIN_BIT 2
`define PCI_BYTE_RESET 8'h00
`define PCI_SYNC_STAGES 2
`endif

// File: pkg/pci_pkg.sv
// Types shared by the port change interrupt logic.
`include "pci_regs.svh"
package pci_pkg;
  typedef struct packed {
    logic [`PCI_PORT_WIDTH-1:0] pin_direction;
    logic [`PCI_PORT_WIDTH-1:0] change_irq_enable;
    logic [`PCI_PORT_WIDTH-1:0] compare_source_select;
    logic [`PCI_PORT_WIDTH-1:0] compare_reference;
    logic [`PCI_PORT_WIDTH-1:0] expander_config;
  } pci_cfg_type;
  typedef struct packed {
    logic irq_active;
    logic [`PCI_PORT_WIDTH-1:0] irq_port_capture;
    logic [`PCI_PORT_WIDTH-1:0] irq_source_flags;
    logic [`PCI_PORT_WIDTH-1:0] prev_level;
  } pci_state_type;
endpackage

// File: core/pci_sync.sv
// Two-stage synchroniser for the port pins.
`timescale 1ns/1ps
`include "pci_regs.svh"
module pci_sync
  import pci_pkg::*;
#(
  parameter int WIDTH = `PCI_PORT_WIDTH
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Asynchronous input and synchronised output.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } pci_sync_state_type;
  pci_sync_state_type state;
  pci_sync_state_type next_state;

  // The first stage feeds only the second stage.
  always_comb
  begin
    next_state.first = i_async;
    next_state.second = state.first;
  end

  // Both stages reset to zero.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      state <= '0;
    else
      state <= next_state;
  end

  assign o_sync = state.second;
endmodule

// File: core/pci_irq.sv
// Interrupt-on-change logic for an 8-bit port expander.
// Contract
// R1: Per-pin enable and compare source select.
// R2: Previous mode: pin differs from recorded level.
// R3: Reference mode: pin differs from reference bit.
// R4: Only enabled input pins take part.
// R5: Output pins never affect interrupt.
// R6: Capture whole port on interrupt.
// R7: Pending interrupt blocks new events and capture.
// R8: Interrupt held until selected register read.
// R9: Writes never change interrupt state.
// R10: Clear after read data LSb shifted out.
// R11: Pending condition reasserts with new capture.
// R12: Previous mode baseline updates at interrupt.
// R13: Reference mismatch persists after read.
// R14: Output is low, high or open-drain.
// R15: Clear select picks capture or port read.
// R16: Open-drain ignores polarity; else driven.
// R17: Polarity set is high, clear is low.
// R18: Flags show pins causing the interrupt.
// R19: Pins synchronised before comparison.
`timescale 1ns/1ps
`include "pci_regs.svh"
module pci_irq
  import pci_pkg::*;
#(
  parameter int WIDTH = `PCI_PORT_WIDTH
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Port pins, asynchronous to the clock.
  input wire logic [WIDTH-1:0] i_port_pins,
  // Configuration held by the register file outside.
  input wire logic [WIDTH-1:0] i_pin_direction,
  input wire logic [WIDTH-1:0] i_change_irq_enable,
  input wire logic [WIDTH-1:0] i_compare_source_select,
  input wire logic [WIDTH-1:0] i_compare_reference,
  input wire logic [7:0] i_expander_config,
  // Pulses from the serial interface when a read's LSb has been shifted out.
  input wire logic i_capture_read_done,
  input wire logic i_port_read_done,
  // Read-only register contents and synchronised port value.
  output logic [WIDTH-1:0] o_irq_port_capture,
  output logic [WIDTH-1:0] o_irq_source_flags,
  output logic [WIDTH-1:0] o_port_value,
  // Interrupt pin as output, output enable and internal level.
  output logic o_irq_pin,
  output logic o_irq_pin_oe,
  output logic o_irq_pending
);
  pci_state_type state;
  pci_state_type next_state;
  logic [WIDTH-1:0] port_sync;
  logic [WIDTH-1:0] eligible;
  logic [WIDTH-1:0] mismatch;
  logic clear_hit;
  logic [WIDTH-1:0] base_after;

  // Pins are resynchronised so a metastable sample never reaches the compare.
  pci_sync #(.WIDTH(WIDTH)) u_sync ( // R19
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_port_pins),
    .o_sync(port_sync)
  );

  // Only enabled inputs qualify; a direction bit of 1 marks an input.
  assign eligible = i_pin_direction & i_change_irq_enable; // R4 R5 R1

  // Each pin compares with its own source, chosen per bit.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_cmp
      assign mismatch[gi] = eligible[gi] & (i_compare_source_select[gi] // R1
        ? (port_sync[gi] != i_compare_reference[gi]) // R3 R13
        : (port_sync[gi] != state.prev_level[gi])); // R2
    end
  endgenerate

  // Only a completed read of the selected register clears; writes have no path here.
  assign clear_hit = i_expander_config[`PCI_CFG_CLEAR_SEL_BIT] // R15 R9
    ? i_capture_read_done : i_port_read_done; // R8 R10

  // Baseline holds for eligible pins while idle, so a change is judged against the level recorded at the last interrupt.
  assign base_after = state.prev_level;

  // Interrupt state update.
  always_comb
  begin
    next_state = state;
    if (state.irq_active && clear_hit)
    begin
      next_state.irq_active = 1'b0; // R10
      next_state.irq_source_flags = '0;
    end
    if ((!state.irq_active || clear_hit) && (mismatch != '0)) // R7
    begin
      // A pending condition at the clearing read re-fires at once with fresh capture.
      next_state.irq_active = 1'b1; // R11 R13
      next_state.irq_port_capture = port_sync; // R6
      next_state.irq_source_flags = mismatch; // R18
      next_state.prev_level = port_sync; // R12
    end
    else if (!state.irq_active)
    begin
      // Non-eligible pins follow the port so enabling later does not fire on stale data.
      next_state.prev_level = (base_after & eligible) | (port_sync & ~eligible);
    end
    // While pending, capture, flags and baseline stay frozen.
  end

  // State registers.
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state.irq_active <= 1'b0;
      state.irq_port_capture <= `PCI_BYTE_RESET;
      state.irq_source_flags <= `PCI_BYTE_RESET;
      state.prev_level <= `PCI_BYTE_RESET;
    end
    else
      state <= next_state;
  end

  // Output driver: open-drain pulls low when active; driven mode uses polarity.
  always_comb
  begin
    if (i_expander_config[`PCI_CFG_OPEN_DRAIN_BIT]) // R16 R14
    begin
      o_irq_pin = 1'b0;
      o_irq_pin_oe = state.irq_active;
    end
    else
    begin
      o_irq_pin = i_expander_config[`PCI_CFG_POLARITY_BIT] ? state.irq_active : !state.irq_active; // R17
      o_irq_pin_oe = 1'b1;
    end
  end

  assign o_irq_port_capture = state.irq_port_capture;
  assign o_irq_source_flags = state.irq_source_flags;
  assign o_port_value = port_sync;
  assign o_irq_pending = state.irq_active;
endmodule

// File: tb/pci_irq_assertions.sv
// Checker for the interrupt behaviour at the block's ports.
`timescale 1ns/1ps
module pci_irq_check
(
  // Watched ports.
  input wire logic i_clk, i_rst, i_capture_read_done, i_port_read_done,
  input wire logic [7:0] i_pin_direction, i_change_irq_enable, i_compare_source_select,
  input wire logic [7:0] i_compare_reference, i_expander_config,
  input wire logic [7:0] o_irq_port_capture, o_irq_source_flags, o_port_value,
  input wire logic o_irq_pin, o_irq_pin_oe, o_irq_pending
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Eligible pins are inputs with their enable set; the reference term only counts them.
  wire logic [7:0] el = i_pin_direction & i_change_irq_enable;
  wire logic refm = |(el & i_compare_source_select & (o_port_value ^ i_compare_reference));
  // Clearing read of the selected register; quiet means every eligible pin uses and matches its reference.
  wire logic clr_sel = i_expander_config[0] ? i_capture_read_done : i_port_read_done;
  wire logic quiet = !refm && ((el & ~i_compare_source_select) == 8'h00);
  sequence s_sel;
    o_irq_pending && clr_sel;
  endsequence
  property p_clr; s_sel ##0 quiet |=> !o_irq_pending; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_hold; o_irq_pending && !clr_sel |=> o_irq_pending && $stable(o_irq_port_capture)
    && $stable(o_irq_source_flags); endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_ref; !o_irq_pending && refm |=> o_irq_pending; endproperty
  a_ref: assert property (p_ref) else $error("no ref irq");
  property p_keep; o_irq_pending && refm |=> o_irq_pending; endproperty
  a_keep: assert property (p_keep) else $error("ref irq lost");
  property p_idle; !o_irq_pending && quiet |=> !o_irq_pending; endproperty
  a_idle: assert property (p_idle) else $error("stray irq");
  property p_cap; $rose(o_irq_pending) |-> o_irq_port_capture == $past(o_port_value); endproperty
  a_cap: assert property (p_cap) else $error("bad capture");
  property p_flag; $rose(o_irq_pending) |-> o_irq_source_flags != 8'h00 && (o_irq_source_flags & ~el) == 8'h00;
  endproperty
  a_flag: assert property (p_flag) else $error("bad flags");
  property p_pin; i_expander_config[2] ? (o_irq_pin_oe == o_irq_pending && !o_irq_pin)
    : (o_irq_pin_oe && o_irq_pin == (o_irq_pending == i_expander_config[1])); endproperty
  a_pin: assert property (p_pin) else $error("bad pin");
endmodule

// File: tb/pci_host.sv
// Host model that reads the capture or port register.
`timescale 1ns/1ps
module pci_host
(
  // Clock and end-of-read pulses.
  input wire logic i_clk,
  output logic o_capture_read_done = 1'b0,
  output logic o_port_read_done = 1'b0
);
  // A read shifts for gap cycles, then pulses for one cycle once the last bit is out.
  task automatic read(input logic cap, input int gap);
    repeat (gap) @(negedge i_clk);
    o_capture_read_done = cap;
    o_port_read_done = !cap;
    @(negedge i_clk);
    o_capture_read_done = 1'b0;
    o_port_read_done = 1'b0;
  endtask
endmodule

// File: tb/pci_irq_bench.sv
// Bench for the port change interrupt logic.
`timescale 1ns/1ps
module pci_irq_bench;
  logic i_clk = 1'b0, i_rst = 1'b1, i_capture_read_done, i_port_read_done, o_irq_pin, o_irq_pin_oe, o_irq_pending;
  logic [7:0] i_port_pins = 8'h00, i_pin_direction = 8'hff, i_change_irq_enable = 8'h0f, i_expander_config = 8'h02;
  logic [7:0] i_compare_source_select = 8'h00, i_compare_reference = 8'h00;
  logic [7:0] o_irq_port_capture, o_irq_source_flags, o_port_value;
  int err_count = 0, samples_checked = 0, cycles = 0;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch %0t %h %h", $time, a, b); end end
  pci_irq dut_u (.*);
  pci_host host_u (.i_clk, .o_capture_read_done(i_capture_read_done), .o_port_read_done(i_port_read_done));
  // Clock, plus a guard far above the sixty or so cycles the tests need.
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Pin changes need the two sync stages plus one edge before they show.
  task automatic pins(input logic [7:0] v);
    i_port_pins = v;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic rd(input logic cap);
    host_u.read(cap, 2);
    @(negedge i_clk);
  endtask
  // Previous-value mode, then reference mode with an output pin and open drain.
  initial
  begin
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
    pins(8'h80);
    `CHK({o_irq_pending, o_port_value}, 9'h080)
    // The edge after the second sync stage is the first that may raise the interrupt.
    i_port_pins = 8'h81;
    repeat (2) @(negedge i_clk);
    `CHK({o_irq_pending, o_port_value}, 9'h081)
    repeat (2) @(negedge i_clk);
    `CHK({o_irq_pending, o_irq_pin, o_irq_port_capture, o_irq_source_flags}, 18'h38101)
    pins(8'h83);
    rd(1'b1);
    `CHK({o_irq_pending, o_irq_port_capture}, 9'h181)
    rd(1'b0);
    `CHK({o_irq_pending, o_irq_port_capture}, 9'h183)
    rd(1'b0);
    pins(8'h82);
    `CHK({o_irq_pending, o_irq_port_capture}, 9'h182)
    // The fall became the new baseline, so the clear must not re-fire.
    rd(1'b0);
    `CHK(o_irq_pending, 1'b0)
    $display("test previous done");
    i_rst = 1'b1;
    i_pin_direction = 8'hfe;
    i_change_irq_enable = 8'hff;
    i_compare_source_select = 8'hff;
    i_expander_config = 8'h07;
    pins(8'h01);
    i_rst = 1'b0;
    pins(8'h01);
    `CHK(o_irq_pending, 1'b0)
    pins(8'h03);
    `CHK({o_irq_pending, o_irq_pin_oe, o_irq_pin}, 3'b110)
    rd(1'b1);
    `CHK(o_irq_pending, 1'b1)
    pins(8'h01);
    rd(1'b1);
    `CHK({o_irq_pending, o_irq_pin_oe}, 2'b00)
    // Pin 7 alone goes back to previous-value mode while the rest keep their reference.
    i_compare_source_select = 8'h7f;
    pins(8'h81);
    `CHK({o_irq_pending, o_irq_port_capture, o_irq_source_flags}, 17'h18180)
    $display("test reference done");
    print_verdict();
  end
endmodule
bind pci_irq pci_irq_check chk_u (.*);
